// ### hdl/acs_cfg.svh
// constants of the conversion sequencer: offsets, fields, resets, timing
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// register byte offsets
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_CFG 8'h04
`define ACS_OFF_RES_LO 8'h08
`define ACS_OFF_RES_HI 8'h0c
`define ACS_OFF_INT 8'h10
`define ACS_OFF_PORT 8'h14
`define ACS_OFF_DIR 8'h18
// field positions
`define ACS_CTRL_ON 0
`define ACS_CTRL_GO 2
`define ACS_CTRL_CHAN 7:4
`define ACS_CFG_CLK 7:6
`define ACS_CFG_ALIGN 5
`define ACS_CFG_PCFG 3:0
`define ACS_INT_FLAG 0
`define ACS_INT_EN 1
// reset values
`define ACS_DIR_RST 16'hffff
`define ACS_PORT_RST 16'h0000
`define ACS_RES_RST 8'h00
// timing: oscillator periods per bit period and per instruction cycle
`define ACS_DIV_8 7'd8
`define ACS_DIV_32 7'd32
`define ACS_DIV_64 7'd64
`define ACS_TCY_CLKS 3'd4
`define ACS_CONV_BITS 4'd10
`define ACS_POST_WAIT 2'd2
`define ACS_SAR_FIRST 10'h200
`endif

// ### hdl/acs_pkg.sv
// types shared by the conversion sequencer files
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_CLK_DIV8,
        ACS_CLK_DIV32,
        ACS_CLK_DIV64,
        ACS_CLK_RC
    } acs_clk_sel_type;

    typedef enum {
        ACS_ST_OFF,
        ACS_ST_ACQ,
        ACS_ST_START,
        ACS_ST_CONV,
        ACS_ST_LAST,
        ACS_ST_WAIT
    } acs_state_type;

    typedef struct packed {
        logic [3:0] channel_select;
        logic go_done;
        logic converter_power_on;
    } acs_ctrl_type;

    typedef struct packed {
        acs_clk_sel_type conv_clock_select;
        logic result_align_select;
        logic [3:0] port_config;
    } acs_cfg_type;

    typedef struct packed {
        logic hold_capacitor_connect;
        logic [3:0] channel_select;
        logic [9:0] trial_code;
        logic digital_source;
        logic vref_external;
    } acs_front_type;
endpackage

// ### hdl/acs_tad_div.sv
// bit period tick generator: oscillator divider or rc clock edge
`include "acs_cfg.svh"
module acs_tad_div (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic restart,
    input wire acs_pkg::acs_clk_sel_type conv_clock_select,
    input wire logic rc_edge,
    // tick out
    output logic tad_tick
);
    import acs_pkg::*;

    logic [6:0] cnt_reg;
    logic [6:0] ratio;

    always_comb begin
        case (conv_clock_select)
            ACS_CLK_DIV8: ratio = `ACS_DIV_8;
            ACS_CLK_DIV32: ratio = `ACS_DIV_32;
            default: ratio = `ACS_DIV_64;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 7'h00;
        end else if (restart || cnt_reg == ratio - 7'h01) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    // on the divided clocks restart holds off the tick so the first period is a full one; the rc edge is not held off
    assign tad_tick = (conv_clock_select == ACS_CLK_RC) ? rc_edge :
                      (!restart && cnt_reg == ratio - 7'h01);
endmodule // acs_tad_div

// ### hdl/acs_sequencer.sv
// conversion sequencer with ahb-lite register slave
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`include "acs_cfg.svh"
module acs_sequencer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // device state
    input wire logic sleep_mode,
    output logic wake_req,
    output logic conv_done_int_flag,
    // analog front end
    input wire logic rc_clock_pin,
    input wire logic comparator_pin,
    output acs_pkg::acs_front_type front,
    // port pins
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    acs_ctrl_type ctrl_reg;
    acs_cfg_type cfg_reg;
    acs_state_type state_reg;
    logic [7:0] res_lo_reg, res_hi_reg, addr_reg;
    logic flag_reg, int_en_reg, wr_reg, rd_wait_reg, wake_reg;
    logic [15:0] port_reg, dir_reg, pin_meta_reg, pin_sync_reg;
    logic [31:0] hrdata_reg, rd_mux;
    logic [9:0] sar_reg;
    logic [3:0] bit_reg;
    logic [1:0] wait_reg;
    logic [2:0] tcy_reg;
    logic cmp_meta_reg, cmp_sync_reg, rc_meta_reg, rc_sync_reg, rc_prev_reg;
    logic accept, wr_now, wr_ctrl, powered, is_rc, tick;
    logic div_restart, busy, abort, finish;
    logic [15:0] analog_mask, result_word;
    // ------------------------------------------------------------
    // synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
            rc_meta_reg <= 1'b0;
            rc_sync_reg <= 1'b0;
            rc_prev_reg <= 1'b0;
            pin_meta_reg <= 16'h0000;
            pin_sync_reg <= 16'h0000;
        end else begin
            cmp_meta_reg <= comparator_pin;
            cmp_sync_reg <= cmp_meta_reg;
            rc_meta_reg <= rc_clock_pin;
            rc_sync_reg <= rc_meta_reg;
            rc_prev_reg <= rc_sync_reg;
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end
    // ------------------------------------------------------------
    // bus address phase and read data
    // ------------------------------------------------------------
    assign accept = hsel && htrans[1] && hready;
    assign wr_now = wr_reg && !rd_wait_reg;
    assign wr_ctrl = wr_now && addr_reg == `ACS_OFF_CTRL;

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
        end else begin
            rd_wait_reg <= accept && !hwrite;
            wr_reg <= accept && hwrite;
            if (accept) begin
                addr_reg <= {haddr[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_wait_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    assign hreadyout = !rd_wait_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // digital pins read back, analog ones read as zero
    assign analog_mask = 16'hffff >> {cfg_reg.port_config[3:1], 1'b0};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            `ACS_OFF_CTRL: rd_mux[7:0] = {ctrl_reg.channel_select, 1'b0,
                ctrl_reg.go_done, 1'b0, ctrl_reg.converter_power_on};
            `ACS_OFF_CFG: rd_mux[7:0] = {cfg_reg.conv_clock_select,
                cfg_reg.result_align_select, 1'b0, cfg_reg.port_config};
            `ACS_OFF_RES_LO: rd_mux[7:0] = res_lo_reg;
            `ACS_OFF_RES_HI: rd_mux[7:0] = res_hi_reg;
            `ACS_OFF_INT: rd_mux[1:0] = {int_en_reg, flag_reg};
            `ACS_OFF_PORT: rd_mux[15:0] = pin_sync_reg & ~analog_mask;
            `ACS_OFF_DIR: rd_mux[15:0] = dir_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // software owns go; hardware clears it on finish or power loss
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg.converter_power_on <= hwdata[`ACS_CTRL_ON];
            ctrl_reg.go_done <= hwdata[`ACS_CTRL_GO];
            ctrl_reg.channel_select <= hwdata[`ACS_CTRL_CHAN];
        end else if (finish || !powered) begin
            ctrl_reg.go_done <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= '{ACS_CLK_DIV8, 1'b0, 4'h0};
        end else if (wr_now && addr_reg == `ACS_OFF_CFG) begin
            cfg_reg.conv_clock_select <=
                acs_clk_sel_type'(hwdata[`ACS_CFG_CLK]);
            cfg_reg.result_align_select <= hwdata[`ACS_CFG_ALIGN];
            cfg_reg.port_config <= hwdata[`ACS_CFG_PCFG];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_reg <= `ACS_PORT_RST;
            dir_reg <= `ACS_DIR_RST;
        end else if (wr_now && addr_reg == `ACS_OFF_PORT) begin
            port_reg <= hwdata[15:0];
        end else if (wr_now && addr_reg == `ACS_OFF_DIR) begin
            dir_reg <= hwdata[15:0];
        end
    end

    // flag: set by completion wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= 1'b0;
            int_en_reg <= 1'b0;
        end else begin
            if (wr_now && addr_reg == `ACS_OFF_INT) begin
                int_en_reg <= hwdata[`ACS_INT_EN];
            end
            if (finish) begin
                flag_reg <= 1'b1;
            end else if (wr_now && addr_reg == `ACS_OFF_INT) begin
                flag_reg <= hwdata[`ACS_INT_FLAG];
            end
        end
    end
    // ------------------------------------------------------------
    // result pair
    // ------------------------------------------------------------
    assign result_word = cfg_reg.result_align_select ?
        {6'h00, sar_reg} : {sar_reg, 6'h00};

    // only a finished conversion or a write with the power bit clear loads, so an abort keeps the pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_lo_reg <= `ACS_RES_RST;
            res_hi_reg <= `ACS_RES_RST;
        end else if (finish) begin
            res_lo_reg <= result_word[7:0];
            res_hi_reg <= result_word[15:8];
        end else if (wr_now && !ctrl_reg.converter_power_on) begin
            if (addr_reg == `ACS_OFF_RES_LO) begin
                res_lo_reg <= hwdata[7:0];
            end
            if (addr_reg == `ACS_OFF_RES_HI) begin
                res_hi_reg <= hwdata[7:0];
            end
        end
    end
    // ------------------------------------------------------------
    // bit period ticks
    // ------------------------------------------------------------
    assign is_rc = cfg_reg.conv_clock_select == ACS_CLK_RC;
    // sleep on a divided oscillator shuts the converter, bit stays set
    assign powered = ctrl_reg.converter_power_on
                     && !(sleep_mode && !is_rc);
    assign div_restart = state_reg == ACS_ST_ACQ && ctrl_reg.go_done;
    acs_tad_div u_tad_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(div_restart),
        .conv_clock_select(cfg_reg.conv_clock_select),
        .rc_edge(rc_sync_reg && !rc_prev_reg),
        .tad_tick(tick)
    );
    // ------------------------------------------------------------
    // conversion sequence
    // ------------------------------------------------------------
    assign busy = state_reg inside {ACS_ST_START, ACS_ST_CONV, ACS_ST_LAST};
    assign abort = busy && !ctrl_reg.go_done;
    assign finish = powered && state_reg == ACS_ST_LAST && tick
                    && ctrl_reg.go_done;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ACS_ST_OFF;
            sar_reg <= 10'h000;
            bit_reg <= 4'h0;
            wait_reg <= 2'b00;
            tcy_reg <= 3'd0;
        end else if (!powered) begin
            state_reg <= ACS_ST_OFF;
        end else if (abort) begin
            state_reg <= ACS_ST_WAIT;
            wait_reg <= 2'b00;
        end else begin
            case (state_reg)
                ACS_ST_OFF: state_reg <= ACS_ST_ACQ;
                ACS_ST_ACQ: begin
                    if (ctrl_reg.go_done) begin
                        state_reg <= ACS_ST_START;
                        tcy_reg <= 3'd1;
                    end
                end
                ACS_ST_START: begin
                    // no tick counts before an instruction cycle has run
                    if (tcy_reg != `ACS_TCY_CLKS) begin
                        tcy_reg <= tcy_reg + 3'd1;
                    end else if (tick) begin
                        state_reg <= ACS_ST_CONV;
                        sar_reg <= `ACS_SAR_FIRST;
                        bit_reg <= `ACS_CONV_BITS - 4'd1;
                    end
                end
                ACS_ST_CONV: begin
                    if (tick) begin
                        sar_reg[bit_reg] <= cmp_sync_reg;
                        if (bit_reg == 4'd0) begin
                            state_reg <= ACS_ST_LAST;
                        end else begin
                            sar_reg[bit_reg - 4'd1] <= 1'b1;
                            bit_reg <= bit_reg - 4'd1;
                        end
                    end
                end
                ACS_ST_LAST: begin
                    if (tick) begin
                        state_reg <= ACS_ST_WAIT;
                        wait_reg <= 2'b00;
                    end
                end
                ACS_ST_WAIT: begin
                    if (tick) begin
                        if (wait_reg == `ACS_POST_WAIT - 2'd1) begin
                            state_reg <= ACS_ST_ACQ;
                        end else begin
                            wait_reg <= wait_reg + 2'd1;
                        end
                    end
                end
                default: state_reg <= ACS_ST_OFF;
            endcase
        end
    end
    // ------------------------------------------------------------
    // sleep wake-up
    // ------------------------------------------------------------
    // no enable: no wake, power bit untouched by completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= finish && sleep_mode && int_en_reg;
        end
    end

    assign wake_req = wake_reg;
    assign conv_done_int_flag = flag_reg;
    // ------------------------------------------------------------
    // front end and pins
    // ------------------------------------------------------------
    // the hold capacitor only connects during acquisition; it is
    // never discharged, only left floating while converting
    assign front.hold_capacitor_connect =
        state_reg == ACS_ST_ACQ;
    assign front.channel_select = ctrl_reg.channel_select;
    assign front.trial_code = sar_reg;
    // an output-driven analog pin converts its own driven level
    assign front.digital_source = !dir_reg[ctrl_reg.channel_select]
        && analog_mask[ctrl_reg.channel_select];
    assign front.vref_external = cfg_reg.port_config[0];
    assign pin_out = port_reg;
    assign pin_oe = ~dir_reg;
endmodule // acs_sequencer

// ### verification/acs_analog_model.sv
// analog side: internal rc oscillator and comparator of the input
module acs_analog_model (
    // analog source level
    input wire logic [9:0] level,
    // converter front end
    input wire acs_pkg::acs_front_type front,
    input wire logic [15:0] pin_out,
    // answers
    output logic comparator_pin,
    output logic rc_clock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;
    logic [9:0] sample;
    // ----------------------------------------
    // rc oscillator, 2 us period, free running
    // ----------------------------------------
    // offset keeps its edges away from the bus clock edges
    initial begin
        rc_clock_pin = 1'b0;
        #7;
        forever #1000 rc_clock_pin = ~rc_clock_pin;
    end
    // a driven analog pin presents its own output level
    assign sample = front.digital_source ?
        {10{pin_out[front.channel_select]}} : level;
    assign comparator_pin = (sample >= front.trial_code);
endmodule // acs_analog_model

// ### verification/acs_sequencer_props.sv
// concurrent assertions on the conversion sequencer ports
module acs_sequencer_props (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // device state and front end
    input wire logic sleep_mode,
    input wire logic wake_req,
    input wire logic conv_done_int_flag,
    input wire acs_pkg::acs_front_type front,
    input wire logic [15:0] pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;
    logic [9:0] low_cnt_reg;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // cycles since the hold capacitor left the input
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_reg <= 10'h0;
        end else if (front.hold_capacitor_connect) begin
            low_cnt_reg <= 10'h0;
        end else if (low_cnt_reg != 10'h3ff) begin
            low_cnt_reg <= low_cnt_reg + 10'h1;
        end
    end
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("slave gave a non okay response");
    read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite
        |=> hreadyout)
        else $error("write data phase stalled");
    // at least eleven bit periods of eight clocks before completion
    conv_span_a: assert property ($rose(conv_done_int_flag)
        |-> low_cnt_reg >= 10'h58)
        else $error("conversion finished too early");
    post_wait_a: assert property ($rose(conv_done_int_flag)
        |-> (!front.hold_capacitor_connect) [*8])
        else $error("hold capacitor reconnected too soon");
    wake_cause_a: assert property (wake_req
        |-> sleep_mode && conv_done_int_flag)
        else $error("wake request without completion in sleep");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    reset_quiet_a: assert property ($rose(hresetn)
        |-> !front.hold_capacitor_connect && !conv_done_int_flag
        && pin_oe == 16'h0)
        else $error("outputs not at reset values");
    cover property ($rose(conv_done_int_flag));
    cover property (wake_req);
    cover property (sleep_mode && $fell(front.hold_capacitor_connect));
endmodule // acs_sequencer_props

bind acs_sequencer acs_sequencer_props acs_sequencer_props_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_mode(sleep_mode), .wake_req(wake_req),
    .conv_done_int_flag(conv_done_int_flag), .front(front),
    .pin_oe(pin_oe)
);

// ### verification/test_acs_sequencer.sv
// self-checking bench for the conversion sequencer
module test_acs_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic sleep_mode = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] pin_in = 16'hffff, pin_out, pin_oe;
    logic [9:0] level = 10'h2b7;
    logic hreadyout, hresp, wake_req, conv_done_int_flag;
    logic rc_clock_pin, comparator_pin;
    acs_front_type front;
    int n_fail = 0, n_compared = 0, n, wakes;

    always #25 hclk = ~hclk;

    acs_sequencer acs_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sleep_mode(sleep_mode), .wake_req(wake_req),
        .conv_done_int_flag(conv_done_int_flag),
        .rc_clock_pin(rc_clock_pin), .comparator_pin(comparator_pin),
        .front(front), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    acs_analog_model acs_analog_model_inst (.level(level), .front(front),
        .pin_out(pin_out), .comparator_pin(comparator_pin),
        .rc_clock_pin(rc_clock_pin));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // one single transfer; waits for the slave, never counts cycles
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic wait_flag(input int lim);
        n = 0;
        wakes = 0;
        while (conv_done_int_flag !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
            if (wake_req === 1'b1) wakes++;
        end
        repeat (3) begin
            @(posedge hclk);
            if (wake_req === 1'b1) wakes++;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rc(8'h00, 32'h0);
        rc(8'h18, 32'hffff);
        rc(8'h1c, 32'h0);
        bus(1'b1, 8'h08, 32'ha5);
        bus(1'b1, 8'h0c, 32'h3c);
        rc(8'h08, 32'ha5);
        rc(8'h0c, 32'h3c);
        bus(1'b1, 8'h04, 32'h0);
        rc(8'h14, 32'h0);
        bus(1'b1, 8'h04, 32'hf);
        rc(8'h14, 32'hfffc);
        chk("vref select", 32'h1, front.vref_external);
    endtask
    task automatic t_conv;
        int div[3] = '{8, 32, 64};
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, 8'h04, {24'h0, 2'(s), 6'h0});
            bus(1'b1, 8'h10, 32'h0);
            bus(1'b1, 8'h00, 32'h31);
            repeat (400) @(posedge hclk);
            bus(1'b1, 8'h00, 32'h35);
            wait_flag(1000);
            chk("conv cycles", 1, n > 12 * div[s] && n <= 12 * div[s] + 6);
            rc(8'h00, 32'h31);
            rc(8'h10, 32'h1);
            rc(8'h0c, {24'h0, level[9:2]});
            rc(8'h08, {24'h0, level[1:0], 6'h0});
            level = level + 10'h155;
        end
    endtask
    // rc clock, right justified, run bit then sleep at once
    task automatic t_sleep_rc(input logic en);
        bus(1'b1, 8'h04, 32'he0);
        bus(1'b1, 8'h10, {30'h0, en, 1'b0});
        repeat (400) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h35);
        sleep_mode <= 1'b1;
        wait_flag(1000);
        chk("rc cycles", 1, n >= 440 && n <= 560);
        chk("wake pulses", {31'h0, en}, wakes);
        rc(8'h00, 32'h31);
        rc(8'h08, {24'h0, level[7:0]});
        rc(8'h0c, {30'h0, level[9:8]});
        sleep_mode <= 1'b0;
    endtask
    task automatic t_abort;
        logic [31:0] r;
        bus(1'b1, 8'h04, 32'h40);
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        r = d;
        bus(1'b1, 8'h00, 32'h35);
        repeat (100) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h31);
        n = 0;
        while (front.hold_capacitor_connect !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk("reacquire", 1, n >= 32 && n <= 70);
        rc(8'h10, 32'h0);
        rc(8'h08, r);
        // non-rc clock: sleep drops the conversion
        bus(1'b1, 8'h00, 32'h35);
        sleep_mode <= 1'b1;
        wait_flag(600);
        chk("sleep abort", 32'h0, conv_done_int_flag);
        chk("hold off", 32'h0, front.hold_capacitor_connect);
        rc(8'h00, 32'h31);
        sleep_mode <= 1'b0;
    endtask
    task automatic t_digital;
        bus(1'b1, 8'h18, 32'hfff7);
        bus(1'b1, 8'h14, 32'h8);
        @(posedge hclk);
        chk("pin drive", 32'h8, {pin_oe & pin_out});
        repeat (40) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h35);
        wait_flag(1000);
        rc(8'h0c, 32'hff);
        rc(8'h08, 32'hc0);
        bus(1'b1, 8'h00, 32'h35);
        repeat (50) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rc(8'h00, 32'h0);
        rc(8'h18, 32'hffff);
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic summarize;
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_conv();
        t_sleep_rc(1'b1);
        t_sleep_rc(1'b0);
        t_abort();
        t_digital();
        summarize();
    end
    // whole run needs about 6000 cycles
    initial begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        summarize();
    end
endmodule // test_acs_sequencer
